// ---- modbus_rtu_register_slave.sv ----
/*
 * Serial holding-register slave on a half-duplex rs-485 line: receives
 * frames, checks them, reads sixteen holding registers, writes all but 01h and 02h, and answers.
 * Assumes rx_in comes from the pin; baud, address and measurement inputs
 * come from logic on clk_in and are steady while a frame is handled.
 */
`timescale 1ns/1ps
`include "modbus_regs.svh"

// Contract
// - characters are one start bit, eight data bits, no parity
// - send two stop bits; accept one or two on receive
// - bit rate selectable from 1200 to 115200, same at both ends
// - everything is a holding register; signed values in two's complement
// - function 03h reads one or a contiguous group of registers
// - function 06h writes one register, 10h writes a contiguous group
// - group read or write frames address at most sixteen registers
// - broadcast requests are carried out but never answered
// - register 01h gives measurement clamped to -999..9999, not writable
// - register 02h gives 0h valid, A0h over range, 60h under range
module modbus_rtu_register_slave (
    input  wire  logic                  clk_in,         // 10 MHz system clock
    input  wire  logic                  rst_n_in,       // async reset, active low
    input  wire  logic                  rx_in,          // line receive data pin
    output logic                        tx_out,         // line transmit data
    output logic                        de_out,         // line driver enable
    input  wire  modbus_pkg::baud_sel_t baud_sel_in,    // bit rate select
    input  wire  logic [7:0]            slave_addr_in,  // own station address
    input  wire  modbus_pkg::hreg_t     meas_value_in,  // signed measurement
    output logic                        param_wr_out,   // parameter write pulse
    output logic [3:0]                  param_addr_out, // written register
    output modbus_pkg::hreg_t           param_data_out  // written value
);
    import modbus_pkg::*;

    state_t      st_r;
    logic        rx_s1_r, rx_s2_r;
    logic [13:0] tmr_r;
    logic [3:0]  bitn_r;
    logic [7:0]  sh_r;
    logic [6:0]  cnt_r;
    logic [15:0] crc_r;
    logic [5:0]  gap_r;
    logic        bad_r;
    logic [7:0]  addr_r, func_r, bc_r, exc_r, hi_r;
    logic [15:0] start_r, qty_r;
    logic [4:0]  idx_r;
    logic [5:0]  txi_r;
    logic [10:0] txsh_r;

    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ `MB_CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    // bit period per selected rate
    wire [13:0] bit_len = (baud_sel_in == 3'h0) ? 14'(`MB_BIT_CYC(1200))  :
                          (baud_sel_in == 3'h1) ? 14'(`MB_BIT_CYC(2400))  :
                          (baud_sel_in == 3'h2) ? 14'(`MB_BIT_CYC(4800))  :
                          (baud_sel_in == 3'h3) ? 14'(`MB_BIT_CYC(9600))  :
                          (baud_sel_in == 3'h4) ? 14'(`MB_BIT_CYC(19200)) :
                          (baud_sel_in == 3'h5) ? 14'(`MB_BIT_CYC(38400)) :
                          (baud_sel_in == 3'h6) ? 14'(`MB_BIT_CYC(57600)) :
                                                  14'(`MB_BIT_CYC(115200));
    wire        tick   = (tmr_r == 14'h0000);
    wire [13:0] reload = bit_len - 14'h0001;

    // receive byte accepted only with a high first stop bit
    wire byte_ok = (st_r == ST_STOP) && tick && rx_s2_r && (cnt_r < `MB_BUF_DEPTH);
    wire bcast   = (addr_r == 8'h00);

    // frame acceptance: crc over whole frame leaves zero
    wire frame_ok = !bad_r && (crc_r == 16'h0000) && (cnt_r >= `MB_MIN_FRAME) &&
                    ((addr_r == slave_addr_in) || bcast);

    // request checks
    wire [6:0]  q2       = {qty_r[5:0], 1'b0};
    wire [16:0] end_reg  = {1'b0, start_r} + {1'b0, qty_r};
    wire        q_ok     = (qty_r != 16'h0000) && (qty_r <= `MB_MAX_REGS);
    wire        range_ok = (end_reg <= `MB_NUM_REGS);
    wire        ro_hit   = (start_r <= 16'h0002) && (end_reg > 17'h00001);
    wire        one_bad  = (start_r > 16'h000f) || (start_r == 16'h0001) ||
                           (start_r == 16'h0002);
    wire [7:0]  exc_w =
        (func_r == `MB_FN_READ)    ? ((!q_ok || cnt_r != `MB_FIX_FRAME) ? `MB_EXC_VALUE :
                                      !range_ok ? `MB_EXC_ADDR : `MB_EXC_NONE) :
        (func_r == `MB_FN_WR_ONE)  ? ((cnt_r != `MB_FIX_FRAME) ? `MB_EXC_VALUE :
                                      one_bad ? `MB_EXC_ADDR : `MB_EXC_NONE) :
        (func_r == `MB_FN_WR_MANY) ? ((!q_ok || bc_r != {1'b0, q2} ||
                                       cnt_r != 7'd9 + q2) ? `MB_EXC_VALUE :
                                      (!range_ok || ro_hit) ? `MB_EXC_ADDR : `MB_EXC_NONE) :
                                     `MB_EXC_FUNC;

    // measurement in twos_complement_format, clamped, with its status
    wire   meas_hi = $signed(meas_value_in) > $signed(`MB_MEAS_MAX);
    wire   meas_lo = $signed(meas_value_in) < $signed(`MB_MEAS_MIN);
    hreg_t meas_w, stat_w;
    assign meas_w = meas_hi ? `MB_MEAS_MAX : meas_lo ? `MB_MEAS_MIN : meas_value_in;
    assign stat_w = meas_hi ? `MB_STAT_HI : meas_lo ? `MB_STAT_LO : `MB_STAT_OK;

    // frame buffer: raw received bytes, group write data read back from byte 7
    wire [7:0] buf_rd;
    wire [5:0] buf_ra = 6'd7 + {idx_r, 1'b0} + {5'd0, (st_r == ST_WRLO)};
    mem_sync #(.W(8), .D(64), .AW(6)) u_frame_buf (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .we_in     (byte_ok),
        .waddr_in  (cnt_r[5:0]),
        .wdata_in  (sh_r),
        .raddr_in  (buf_ra),
        .rdata_out (buf_rd)
    );

    // holding registers; 01h and 02h are served live instead
    wire [5:0] txd    = txi_r - 6'd3;
    wire [3:0] rd_reg = start_r[3:0] + 4'(txd >> 1);
    hreg_t     reg_rd, rd_word;
    wire       reg_we = (st_r == ST_WRCOMMIT) ||
                        ((st_r == ST_CHECK) && frame_ok && func_r == `MB_FN_WR_ONE &&
                         exc_w == `MB_EXC_NONE);
    wire [3:0] reg_wa = (st_r == ST_WRCOMMIT) ? start_r[3:0] + idx_r[3:0] : start_r[3:0];
    hreg_t     reg_wd;
    assign reg_wd  = (st_r == ST_WRCOMMIT) ? {hi_r, buf_rd} : qty_r;
    assign rd_word = (rd_reg == `MB_REG_MEAS) ? meas_w :
                     (rd_reg == `MB_REG_STAT) ? stat_w : reg_rd;
    mem_sync #(.W(16), .D(16), .AW(4)) u_hold_regs (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .we_in     (reg_we),
        .waddr_in  (reg_wa),
        .wdata_in  (reg_wd),
        .raddr_in  (rd_reg),
        .rdata_out (reg_rd)
    );

    // answer bytes: header, data or echo, then crc low byte first
    wire       is_exc = (exc_r != `MB_EXC_NONE);
    wire [5:0] tx_len = is_exc ? 6'd5 : (func_r == `MB_FN_READ) ? 6'd5 + q2[5:0] : 6'd8;
    wire       tx_crc = (txi_r >= tx_len - 6'd2);
    wire [7:0] tx_byte =
        (txi_r == tx_len - 6'd2) ? crc_r[7:0] :
        (txi_r == tx_len - 6'd1) ? crc_r[15:8] :
        (txi_r == 6'd0) ? addr_r :
        (txi_r == 6'd1) ? (is_exc ? (func_r | `MB_FN_EXC_BIT) : func_r) :
        is_exc ? exc_r :
        (func_r == `MB_FN_READ) ? ((txi_r == 6'd2) ? {1'b0, q2} :
                                   txd[0] ? rd_word[7:0] : rd_word[15:8]) :
        (txi_r == 6'd2) ? start_r[15:8] :
        (txi_r == 6'd3) ? start_r[7:0] :
        (txi_r == 6'd4) ? qty_r[15:8] : qty_r[7:0];

    assign tx_out = txsh_r[0];

    // pin synchroniser
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= rx_in;
            rx_s2_r <= rx_s1_r;
        end
    end

    // request header captured as it arrives, bytes 0..6
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_r  <= 8'h00;
            func_r  <= 8'h00;
            start_r <= 16'h0000;
            qty_r   <= 16'h0000;
            bc_r    <= 8'h00;
        end else if (byte_ok) begin
            case (cnt_r)
                7'd0: addr_r <= sh_r;
                7'd1: func_r <= sh_r;
                7'd2: start_r[15:8] <= sh_r;
                7'd3: start_r[7:0] <= sh_r;
                7'd4: qty_r[15:8] <= sh_r;
                7'd5: qty_r[7:0] <= sh_r;
                7'd6: bc_r <= sh_r;
                default: ;
            endcase
        end
    end

    // registered copy of each accepted register write
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            param_wr_out   <= 1'b0;
            param_addr_out <= 4'h0;
            param_data_out <= 16'h0000;
        end else begin
            param_wr_out <= reg_we;
            if (reg_we) begin
                param_addr_out <= reg_wa;
                param_data_out <= reg_wd;
            end
        end
    end

    // main sequencer; receive is ignored while answering, the line is half duplex
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= ST_IDLE;  tmr_r <= 14'h0000;  bitn_r <= 4'h0;  sh_r <= 8'h00;
            cnt_r <= 7'd0;    crc_r <= `MB_CRC_INIT;  gap_r <= 6'd0;  bad_r <= 1'b0;
            exc_r <= 8'h00;   hi_r <= 8'h00;  idx_r <= 5'd0;  txi_r <= 6'd0;
            txsh_r <= 11'h7ff;  de_out <= 1'b0;
        end else begin
            tmr_r <= tick ? reload : tmr_r - 14'h0001;
            case (st_r)
                ST_IDLE: begin
                    if (tick && gap_r != `MB_GAP_BITS) begin
                        gap_r <= gap_r + 6'd1;
                    end
                    if (cnt_r != 7'd0 && gap_r == `MB_GAP_BITS) begin
                        st_r <= ST_CHECK;
                    end else if (!rx_s2_r) begin
                        tmr_r <= bit_len >> 1;                            // mid start bit
                        st_r  <= ST_START;
                    end
                end
                ST_START: if (tick) begin
                    bitn_r <= 4'h0;
                    st_r   <= rx_s2_r ? ST_IDLE : ST_DATA;                // glitch rejected
                end
                ST_DATA: if (tick) begin
                    sh_r   <= {rx_s2_r, sh_r[7:1]};
                    bitn_r <= bitn_r + 4'h1;
                    if (bitn_r == 4'h7) begin
                        st_r <= ST_STOP;
                    end
                end
                ST_STOP: if (tick) begin
                    gap_r <= 6'd0;
                    if (byte_ok) begin
                        cnt_r <= cnt_r + 7'd1;
                        crc_r <= crc_upd(crc_r, sh_r);
                    end else begin
                        bad_r <= 1'b1;                                    // framing or overflow
                    end
                    st_r <= ST_IDLE;
                end
                ST_CHECK: begin
                    cnt_r <= 7'd0;  bad_r <= 1'b0;  crc_r <= `MB_CRC_INIT;
                    idx_r <= 5'd0;  txi_r <= 6'd0;  exc_r <= exc_w;
                    if (!frame_ok) begin
                        st_r <= ST_IDLE;
                    end else if (exc_w == `MB_EXC_NONE && func_r == `MB_FN_WR_MANY) begin
                        st_r <= ST_WRHI;
                    end else begin
                        st_r <= bcast ? ST_IDLE : ST_TXLOAD;
                    end
                end
                ST_WRHI: st_r <= ST_WRLO;
                ST_WRLO: begin
                    hi_r <= buf_rd;
                    st_r <= ST_WRCOMMIT;
                end
                ST_WRCOMMIT: begin
                    idx_r <= idx_r + 5'd1;
                    if (16'(idx_r) + 16'h0001 == qty_r) begin
                        st_r <= bcast ? ST_IDLE : ST_TXLOAD;
                    end else begin
                        st_r <= ST_WRHI;
                    end
                end
                ST_TXLOAD: st_r <= ST_TXPREP;                             // wait for read data
                ST_TXPREP: begin
                    txsh_r <= {2'b11, tx_byte, 1'b0};
                    if (!tx_crc) begin
                        crc_r <= crc_upd(crc_r, tx_byte);
                    end
                    de_out <= 1'b1;
                    tmr_r  <= reload;
                    bitn_r <= 4'h0;
                    st_r   <= ST_TXBIT;
                end
                ST_TXBIT: if (tick) begin
                    txsh_r <= {1'b1, txsh_r[10:1]};
                    bitn_r <= bitn_r + 4'h1;
                    if (bitn_r == 4'd10) begin
                        txi_r <= txi_r + 6'd1;
                        st_r  <= ST_TXLOAD;
                        if (txi_r == tx_len - 6'd1) begin
                            de_out <= 1'b0;
                            crc_r  <= `MB_CRC_INIT;
                            gap_r  <= 6'd0;
                            st_r   <= ST_IDLE;
                        end
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_start_bit_low: assert property ((st_r == ST_TXBIT && bitn_r == 4'h0) |-> !tx_out)
        else $error("start bit not low");
    a_two_stop_bits: assert property ((st_r == ST_TXBIT && bitn_r >= 4'd9) |-> tx_out)
        else $error("stop bit not high");
    a_bit_period: assert property ((st_r == ST_TXBIT && tick && bitn_r < 4'd10)
        |=> tmr_r == bit_len - 14'h0001) else $error("bit period wrong");
    a_read_limit: assert property ((st_r == ST_CHECK && frame_ok && func_r == `MB_FN_READ
        && qty_r > `MB_MAX_REGS) |=> exc_r == `MB_EXC_VALUE) else $error("group limit missed");
    a_single_write: assert property ((st_r == ST_CHECK && frame_ok && exc_w == 8'h00
        && func_r == `MB_FN_WR_ONE) |=> param_wr_out && param_data_out == $past(qty_r))
        else $error("single write lost");
    a_broadcast_quiet: assert property ((st_r == ST_TXPREP) |-> !bcast)
        else $error("answer to broadcast");
    a_meas_clamped: assert property ((rd_reg == `MB_REG_MEAS) |-> ($signed(rd_word) <=
        $signed(`MB_MEAS_MAX) && $signed(rd_word) >= $signed(`MB_MEAS_MIN)))
        else $error("measurement out of span");
    a_meas_protect: assert property (reg_we |-> (reg_wa != `MB_REG_MEAS &&
        reg_wa != `MB_REG_STAT)) else $error("read-only register written");
    a_status_code: assert property (meas_hi |-> stat_w == `MB_STAT_HI)
        else $error("over range status wrong");
    a_crc_drop: assert property ((st_r == ST_CHECK && crc_r != 16'h0000)
        |=> st_r == ST_IDLE && !de_out) else $error("bad crc frame not dropped");
endmodule

// ---- modbus_regs.svh ----
/*
 * Constants of the serial holding-register slave: clock rate, bit rates,
 * frame gap, function and exception codes, register numbers and status codes.
 * Assumes it is included by bare name from every file that needs it.
 */
`ifndef MODBUS_REGS_SVH
`define MODBUS_REGS_SVH

// system clock and bit period in cycles, rounded down
`define MB_CLK_HZ      10000000
`define MB_BIT_CYC(r)  (`MB_CLK_HZ / (r))

// 3.5 characters of 11 bit times each, rounded up to whole bits
`define MB_GAP_BITS    6'd39

// frame sizes
`define MB_BUF_DEPTH   7'd64
`define MB_MIN_FRAME   7'd4
`define MB_FIX_FRAME   7'd8
`define MB_MAX_REGS    16'h0010
`define MB_NUM_REGS    17'h00010

// function codes
`define MB_FN_READ     8'h03
`define MB_FN_WR_ONE   8'h06
`define MB_FN_WR_MANY  8'h10
`define MB_FN_EXC_BIT  8'h80

// exception codes
`define MB_EXC_NONE    8'h00
`define MB_EXC_FUNC    8'h01
`define MB_EXC_ADDR    8'h02
`define MB_EXC_VALUE   8'h03

// read-only registers and their contents
`define MB_REG_MEAS    4'h1
`define MB_REG_STAT    4'h2
`define MB_MEAS_MAX    16'h270f
`define MB_MEAS_MIN    16'hfc19
`define MB_STAT_OK     16'h0000
`define MB_STAT_HI     16'h00a0
`define MB_STAT_LO     16'h0060

// frame check
`define MB_CRC_INIT    16'hffff
`define MB_CRC_POLY    16'ha001

`endif

// ---- modbus_pkg.sv ----
/*
 * Types shared by the serial holding-register slave.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package modbus_pkg;

    typedef logic [2:0]  baud_sel_t;   // 0..7 = 1200,2400,4800,9600,19200,38400,57600,115200
    typedef logic [15:0] hreg_t;       // one holding register word

    typedef enum {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP,
        ST_CHECK,
        ST_WRHI,
        ST_WRLO,
        ST_WRCOMMIT,
        ST_TXLOAD,
        ST_TXPREP,
        ST_TXBIT
    } state_t;

endpackage

// ---- mem_sync.sv ----
/*
 * Small synchronous memory with one write port and a registered read port.
 * Assumes a single clock; contents are undefined after reset.
 */
`timescale 1ns/1ps

module mem_sync #(
    parameter int W  = 8,
    parameter int D  = 64,
    parameter int AW = 6
) (
    input  wire  logic          clk_in,     // system clock
    input  wire  logic          rst_n_in,   // async reset, active low
    input  wire  logic          we_in,      // write strobe
    input  wire  logic [AW-1:0] waddr_in,   // write address
    input  wire  logic [W-1:0]  wdata_in,   // write data
    input  wire  logic [AW-1:0] raddr_in,   // read address
    output logic       [W-1:0]  rdata_out   // read data, one cycle late
);
    logic [W-1:0] mem_r [D];

    // array carries no reset so it maps onto plain ram
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_r[waddr_in] <= wdata_in;
        end
    end

    // read data always leaves through a register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= mem_r[raddr_in];
        end
    end
endmodule

// ---- modbus_master_model.sv ----
/*
 * Behavioural line master: sends request frames on the slave's receive pin
 * and deframes the slave's answer characters, one strobe per character.
 * Assumes one 10 MHz clock and a biased bus that idles high when released.
 */
`timescale 1ns/1ps

module modbus_master_model #(
    parameter int BIT = 86
) (
    input  wire  logic       clk_in,    // system clock
    output logic             line_out,  // drives slave receive pin
    input  wire  logic       tx_in,     // slave transmit data
    input  wire  logic       de_in,     // slave driver enable
    output logic [7:0]       byte_out,  // received character
    output logic [1:0]       stops_out, // both stop bits as seen
    output logic             stb_out    // one-cycle character strobe
);
    // undriven bus reads high through the failsafe bias
    wire line = de_in ? tx_in : 1'b1;

    initial begin
        line_out  = 1'b1;
        byte_out  = 8'h00;
        stops_out = 2'b00;
        stb_out   = 1'b0;
    end

    // one bit time, changed just after the falling edge
    task automatic put(input logic v);
        line_out = v;
        repeat (BIT) @(negedge clk_in);
    endtask

    // start bit, eight data bits lsb first, one or two stop bits
    task automatic send_frame(input logic [7:0] f[$], input int nstop);
        @(negedge clk_in);
        foreach (f[i]) begin
            put(1'b0);
            for (int j = 0; j < 8; j++) put(f[i][j]);
            repeat (nstop) put(1'b1);
        end
    endtask

    // sample each answer bit mid-cell; stops are kept so both can be judged
    always begin : deframe
        logic [7:0] b;
        logic [1:0] s;
        do @(posedge clk_in); while (line !== 1'b0);
        repeat (BIT / 2) @(posedge clk_in);
        for (int j = 0; j < 8; j++) begin
            repeat (BIT) @(posedge clk_in);
            b[j] = line;
        end
        repeat (BIT) @(posedge clk_in);
        s[0] = line;
        repeat (BIT) @(posedge clk_in);
        s[1] = line;
        byte_out  <= b;
        stops_out <= s;
        stb_out   <= 1'b1;
        @(posedge clk_in);
        stb_out   <= 1'b0;
    end
endmodule

// ---- tb.sv ----
/*
 * Self-checking bench of the holding-register slave at 115200 bit/s.
 * Assumes the master model above and the slave's constants header.
 */
`timescale 1ns/1ps
`include "modbus_regs.svh"

module tb;
    import modbus_pkg::*;
    localparam int         BIT = `MB_BIT_CYC(115200);
    localparam logic [7:0] ME  = 8'h11;

    logic       clk_in   = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       rx_line, tx_out, de_out, param_wr_out, stb;
    logic [3:0] param_addr_out;
    hreg_t      param_data_out, meas, w0, d1, d2, mx, st;
    logic [7:0] rx_byte;
    logic [1:0] stops;
    logic [31:0] rnd = 32'd37;
    logic [7:0]  exp_q[$];
    logic [19:0] par_q[$];
    int errors = 0;
    int n_compared = 0;

    always #50 clk_in = ~clk_in;

    modbus_rtu_register_slave dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .rx_in(rx_line), .tx_out(tx_out),
        .de_out(de_out), .baud_sel_in(3'h7), .slave_addr_in(ME),
        .meas_value_in(meas), .param_wr_out(param_wr_out),
        .param_addr_out(param_addr_out), .param_data_out(param_data_out));

    modbus_master_model #(.BIT(BIT)) master (
        .clk_in(clk_in), .line_out(rx_line), .tx_in(tx_out), .de_in(de_out),
        .byte_out(rx_byte), .stops_out(stops), .stb_out(stb));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c = `MB_CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ `MB_CRC_POLY : c >> 1;
        end
        return c;
    endfunction

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // answer bytes followed by their check word, low byte first
    task automatic expect_ans(input logic [7:0] a[$]);
        logic [15:0] c;
        c = crc16(a);
        foreach (a[i]) exp_q.push_back(a[i]);
        exp_q.push_back(c[7:0]);
        exp_q.push_back(c[15:8]);
    endtask

    // silent frames need the full gap before the next request
    task automatic xfer(input logic [7:0] f[$], input int nstop, input bit bad, input bit ans);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        master.send_frame(f, nstop);
        for (int i = 0; i < 200 * BIT && exp_q.size() != 0; i++) @(negedge clk_in);
        repeat ((ans ? 4 : 42) * BIT) @(negedge clk_in);
        check(20'(exp_q.size()), 20'h0);
        check(20'(par_q.size()), 20'h0);
    endtask

    // any answer character or write pulse is matched against the oldest note
    always @(posedge clk_in) begin
        if (stb === 1'b1) begin
            if (exp_q.size() == 0)
                check({12'h0, rx_byte}, 20'hfffff);
            else begin
                check({12'h0, rx_byte}, {12'h0, exp_q.pop_front()});
                check({18'h0, stops}, 20'h3);
            end
        end
        if (param_wr_out === 1'b1) begin
            if (par_q.size() == 0)
                check({param_addr_out, param_data_out}, 20'hfffff);
            else
                check({param_addr_out, param_data_out}, par_q.pop_front());
        end
    end

    // the five frames and their answers need about 83000 cycles at this rate
    initial begin
        repeat (95000) @(posedge clk_in);
        errors++;
        end_of_test();
    end

    initial begin
        meas = 16'h0000;
        repeat (4) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        check({17'h0, tx_out, de_out, param_wr_out}, 20'h4);
        // single write, sent with one stop bit
        rnd = xs(rnd);
        w0 = rnd[15:0];
        par_q.push_back({4'h0, w0});
        expect_ans('{ME, 8'h06, 8'h00, 8'h00, w0[15:8], w0[7:0]});
        xfer('{ME, 8'h06, 8'h00, 8'h00, w0[15:8], w0[7:0]}, 1, 1'b0, 1'b1);
        // group read across the measurement and status words
        rnd = xs(rnd);
        meas = rnd[15:0];
        if ($signed(meas) > $signed(`MB_MEAS_MAX)) begin
            mx = `MB_MEAS_MAX;
            st = `MB_STAT_HI;
        end else if ($signed(meas) < $signed(`MB_MEAS_MIN)) begin
            mx = `MB_MEAS_MIN;
            st = `MB_STAT_LO;
        end else begin
            mx = meas;
            st = `MB_STAT_OK;
        end
        expect_ans('{ME, 8'h03, 8'h06, w0[15:8], w0[7:0], mx[15:8], mx[7:0],
                     st[15:8], st[7:0]});
        xfer('{ME, 8'h03, 8'h00, 8'h00, 8'h00, 8'h03}, 2, 1'b0, 1'b1);
        // broadcast group write: carried out, never answered
        rnd = xs(rnd);
        d1 = rnd[15:0];
        rnd = xs(rnd);
        d2 = rnd[15:0];
        par_q.push_back({4'h3, d1});
        par_q.push_back({4'h4, d2});
        xfer('{8'h00, 8'h10, 8'h00, 8'h03, 8'h00, 8'h02, 8'h04,
               d1[15:8], d1[7:0], d2[15:8], d2[7:0]}, 2, 1'b0, 1'b0);
        // corrupted check word: no write, no answer
        xfer('{ME, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34}, 2, 1'b1, 1'b0);
        // seventeen registers is one too many
        expect_ans('{ME, 8'h83, 8'h03});
        xfer('{ME, 8'h03, 8'h00, 8'h00, 8'h00, 8'h11}, 2, 1'b0, 1'b1);
        end_of_test();
    end
endmodule
